// >>> logic/ihd_pkg.sv
// Package of constants for the inrush harmonic detector
package ihd_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int MAG_W = 16;
	localparam int PCT_W = 8;
	localparam int PROD_W = 24;

	////////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [11:0] OFF_CTRL = 12'h000;
	localparam logic [11:0] OFF_RATIO = 12'h004;
	localparam logic [11:0] OFF_MINF = 12'h008;
	localparam logic [11:0] OFF_FLAGS = 12'h00c;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h014;
	localparam logic [11:0] OFF_RATED = 12'h018;

	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int IRQ_ON_BIT = 0;
	localparam int IRQ_OFF_BIT = 1;
	localparam int FLAGS_ANY_BIT = 3;

	////////////////////////////////////////////////////////////////////////////
	// Setting ranges and reset values
	localparam logic [PCT_W-1:0] RATIO_MIN = 8'h05;
	localparam logic [PCT_W-1:0] RATIO_MAX = 8'h32;
	localparam logic [PCT_W-1:0] RATIO_RST = 8'h0f;
	localparam logic [PCT_W-1:0] MINF_MIN = 8'h14;
	localparam logic [PCT_W-1:0] MINF_MAX = 8'h64;
	localparam logic [PCT_W-1:0] MINF_RST = 8'h1e;
	localparam logic [MAG_W-1:0] RATED_RST = 16'h1000;
	localparam logic [PCT_W-1:0] PCT_FULL = 8'h64;
	localparam logic [31:0] SLV_ERR_DATA = 32'h0000_0000;

endpackage : ihd_pkg

// >>> logic/ihd_phase.sv
// One phase comparison path of the inrush detector
module ihd_phase (
	// Magnitudes
	input wire logic [15:0] fund_mag,
	input wire logic [15:0] harm2_mag,
	// Settings
	input wire logic [7:0] ratio_pct,
	input wire logic [23:0] min_fund_scaled,
	// Result
	output logic detect
);
	////////////////////////////////////////////////////////////////////////////
	// Percentage arithmetic
	function automatic logic [23:0] scale(input logic [15:0] m, input logic [7:0] p);
		scale = 24'(m) * 24'(p);
	endfunction

	wire logic [23:0] harm_x100;
	wire logic [23:0] fund_x_ratio;
	wire logic [23:0] fund_x100;
	wire logic ratio_hit;
	wire logic level_ok;

	assign harm_x100 = scale(harm2_mag, ihd_pkg::PCT_FULL);
	assign fund_x_ratio = scale(fund_mag, ratio_pct);
	assign fund_x100 = scale(fund_mag, ihd_pkg::PCT_FULL);
	assign ratio_hit = harm_x100 > fund_x_ratio;
	assign level_ok = fund_x100 > min_fund_scaled;
	assign detect = ratio_hit && level_ok;
endmodule // ihd_phase

// >>> logic/ihd_top.sv
// Inrush harmonic detector with APB registers
module ihd_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Magnitudes per phase
	input wire logic [15:0] fund1_mag,
	input wire logic [15:0] fund2_mag,
	input wire logic [15:0] fund3_mag,
	input wire logic [15:0] harm2_1_mag,
	input wire logic [15:0] harm2_2_mag,
	input wire logic [15:0] harm2_3_mag,
	// Blocking input
	input wire logic block_input,
	// Flags
	output logic inrush_phase1_flag,
	output logic inrush_phase2_flag,
	output logic inrush_phase3_flag,
	output logic inrush_any_flag,
	// Events
	output logic event_on,
	output logic event_off,
	// Interrupt
	output logic irq
);
	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic enable_reg;
	logic [7:0] harmonic_ratio_setting_reg;
	logic [7:0] min_fundamental_setting_reg;
	logic [7:0] rated_reg;
	logic [7:0] rated_hi_reg;
	logic phase1_reg;
	logic phase2_reg;
	logic phase3_reg;
	logic any_reg;
	logic event_on_reg;
	logic event_off_reg;
	logic irq_on_reg;
	logic irq_off_reg;
	logic [1:0] irq_mask_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Setting clamp
	function automatic logic [7:0] clamp(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire logic acc;
	wire logic wr;
	wire logic rd;
	wire logic hit_ctrl;
	wire logic hit_ratio;
	wire logic hit_minf;
	wire logic hit_flags;
	wire logic hit_stat;
	wire logic hit_mask;
	wire logic hit_rated;
	wire logic mapped;
	wire logic lane0;
	wire logic lane1;

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign hit_ctrl = paddr == ihd_pkg::OFF_CTRL;
	assign hit_ratio = paddr == ihd_pkg::OFF_RATIO;
	assign hit_minf = paddr == ihd_pkg::OFF_MINF;
	assign hit_flags = paddr == ihd_pkg::OFF_FLAGS;
	assign hit_stat = paddr == ihd_pkg::OFF_IRQ_STAT;
	assign hit_mask = paddr == ihd_pkg::OFF_IRQ_MASK;
	assign hit_rated = paddr == ihd_pkg::OFF_RATED;
	assign mapped = hit_ctrl | hit_ratio | hit_minf | hit_flags | hit_stat | hit_mask | hit_rated;
	assign lane0 = pstrb[0];
	assign lane1 = pstrb[1];

	////////////////////////////////////////////////////////////////////////////
	// Phase paths
	wire logic [15:0] rated_full;
	wire logic [23:0] min_fund_scaled;
	wire logic [2:0] detect;
	wire logic [15:0] fund_mag [3];
	wire logic [15:0] harm_mag [3];

	// Rated current as seen by the threshold
	assign rated_full = {rated_hi_reg, rated_reg};
	// Fundamental threshold in magnitude units times 100
	assign min_fund_scaled = 24'(rated_full) * 24'(min_fundamental_setting_reg);
	// Upstream supplies both magnitudes per phase
	assign fund_mag[0] = fund1_mag;
	assign fund_mag[1] = fund2_mag;
	assign fund_mag[2] = fund3_mag;
	assign harm_mag[0] = harm2_1_mag;
	assign harm_mag[1] = harm2_2_mag;
	assign harm_mag[2] = harm2_3_mag;

	for (genvar i = 0; i < 3; i++) begin : g_phase
		ihd_phase u_phase (
			.fund_mag(fund_mag[i]),
			.harm2_mag(harm_mag[i]),
			.ratio_pct(harmonic_ratio_setting_reg),
			.min_fund_scaled(min_fund_scaled),
			.detect(detect[i])
		);
	end

	////////////////////////////////////////////////////////////////////////////
	// Flag logic
	wire logic active;
	wire logic [2:0] phase_next;
	wire logic any_next;
	wire logic rise;
	wire logic fall;

	assign active = enable_reg && !block_input;
	assign phase_next = active ? detect : 3'b000;
	assign any_next = |phase_next;
	assign rise = any_next && !any_reg;
	assign fall = !any_next && any_reg;

	// Phase one flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase1_reg <= 1'b0;
		end else begin
			phase1_reg <= phase_next[0];
		end
	end

	// Phase two flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase2_reg <= 1'b0;
		end else begin
			phase2_reg <= phase_next[1];
		end
	end

	// Phase three flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase3_reg <= 1'b0;
		end else begin
			phase3_reg <= phase_next[2];
		end
	end

	// General flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			any_reg <= 1'b0;
		end else begin
			any_reg <= any_next;
		end
	end

	// On event, same edge as the general flag rises
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_on_reg <= 1'b0;
		end else begin
			event_on_reg <= rise;
		end
	end

	// Off event, same edge as the general flag falls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_off_reg <= 1'b0;
		end else begin
			event_off_reg <= fall;
		end
	end

	assign inrush_phase1_flag = phase1_reg;
	assign inrush_phase2_flag = phase2_reg;
	assign inrush_phase3_flag = phase3_reg;
	assign inrush_any_flag = any_reg;
	assign event_on = event_on_reg;
	assign event_off = event_off_reg;

	////////////////////////////////////////////////////////////////////////////
	// Write enables
	wire logic wr_lo;
	wire logic wr_ctrl;
	wire logic wr_ratio;
	wire logic wr_minf;
	wire logic wr_mask;
	wire logic wr_rated_lo;
	wire logic wr_rated_hi;
	wire logic [7:0] ratio_wr;
	wire logic [7:0] minf_wr;

	assign wr_lo = wr && lane0;
	assign wr_ctrl = wr_lo && hit_ctrl;
	assign wr_ratio = wr_lo && hit_ratio;
	assign wr_minf = wr_lo && hit_minf;
	assign wr_mask = wr_lo && hit_mask;
	assign wr_rated_lo = wr_lo && hit_rated;
	assign wr_rated_hi = wr && lane1 && hit_rated;
	assign ratio_wr = clamp(pwdata[7:0], ihd_pkg::RATIO_MIN, ihd_pkg::RATIO_MAX);
	assign minf_wr = clamp(pwdata[7:0], ihd_pkg::MINF_MIN, ihd_pkg::MINF_MAX);

	////////////////////////////////////////////////////////////////////////////
	// Settings registers
	// Operation enable, off after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_reg <= 1'b0;
		end else if (wr_ctrl) begin
			enable_reg <= pwdata[ihd_pkg::CTRL_EN_BIT];
		end
	end

	// Harmonic ratio, clamped into range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			harmonic_ratio_setting_reg <= ihd_pkg::RATIO_RST;
		end else if (wr_ratio) begin
			harmonic_ratio_setting_reg <= ratio_wr;
		end
	end

	// Minimum fundamental level, clamped into range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			min_fundamental_setting_reg <= ihd_pkg::MINF_RST;
		end else if (wr_minf) begin
			min_fundamental_setting_reg <= minf_wr;
		end
	end

	// Interrupt mask
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= 2'b00;
		end else if (wr_mask) begin
			irq_mask_reg <= pwdata[1:0];
		end
	end

	// Rated current, low byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rated_reg <= ihd_pkg::RATED_RST[7:0];
		end else if (wr_rated_lo) begin
			rated_reg <= pwdata[7:0];
		end
	end

	// Rated current, high byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rated_hi_reg <= ihd_pkg::RATED_RST[15:8];
		end else if (wr_rated_hi) begin
			rated_hi_reg <= pwdata[15:8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt status, set wins over read clear
	wire logic [1:0] irq_stat;
	wire logic stat_clr;
	wire logic [1:0] stat_clr_mask;
	wire logic [1:0] stat_next;

	assign irq_stat = {irq_off_reg, irq_on_reg};
	assign stat_clr = rd && hit_stat;
	// Only bits already returned in the read word are cleared
	assign stat_clr_mask = stat_clr ? prdata_reg[1:0] : 2'b00;
	assign stat_next = (irq_stat & ~stat_clr_mask) | {event_off_reg, event_on_reg};

	// On event status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_on_reg <= 1'b0;
		end else begin
			irq_on_reg <= stat_next[ihd_pkg::IRQ_ON_BIT];
		end
	end

	// Off event status
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_off_reg <= 1'b0;
		end else begin
			irq_off_reg <= stat_next[ihd_pkg::IRQ_OFF_BIT];
		end
	end

	assign irq = |(irq_stat & irq_mask_reg);

	////////////////////////////////////////////////////////////////////////////
	// Read data
	wire logic setup;
	wire logic [31:0] rd_ctrl;
	wire logic [31:0] rd_ratio;
	wire logic [31:0] rd_minf;
	wire logic [31:0] rd_flags;
	wire logic [31:0] rd_stat;
	wire logic [31:0] rd_mask;
	wire logic [31:0] rd_rated;
	wire logic [31:0] rd_mux;

	assign setup = psel && !penable;
	assign rd_ctrl = {31'h0000_0000, enable_reg};
	assign rd_ratio = {24'h00_0000, harmonic_ratio_setting_reg};
	assign rd_minf = {24'h00_0000, min_fundamental_setting_reg};
	assign rd_flags = {28'h000_0000, any_reg, phase3_reg, phase2_reg, phase1_reg};
	assign rd_stat = {30'h0000_0000, irq_stat};
	assign rd_mask = {30'h0000_0000, irq_mask_reg};
	assign rd_rated = {16'h0000, rated_full};
	assign rd_mux = hit_ctrl ? rd_ctrl :
		hit_ratio ? rd_ratio :
		hit_minf ? rd_minf :
		hit_flags ? rd_flags :
		hit_stat ? rd_stat :
		hit_mask ? rd_mask :
		hit_rated ? rd_rated :
		ihd_pkg::SLV_ERR_DATA;

	// Read word, captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
		end else if (setup) begin
			prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end

	// Error flag for unmapped addresses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_reg <= 1'b0;
		end else if (setup) begin
			pslverr_reg <= !mapped;
		end
	end

	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg && acc;
	assign pready = 1'b1;
endmodule // ihd_top

// >>> testbench/ihd_src.sv
// Upstream magnitude source model
module ihd_src (
	// Clock
	input wire logic pclk,
	// Requested magnitudes, phase 1 in low bits
	input wire logic [47:0] fund_set,
	input wire logic [47:0] harm_set,
	// Magnitudes
	output logic [15:0] fund1_mag,
	output logic [15:0] fund2_mag,
	output logic [15:0] fund3_mag,
	output logic [15:0] harm2_1_mag,
	output logic [15:0] harm2_2_mag,
	output logic [15:0] harm2_3_mag
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge pclk) begin
		{fund3_mag, fund2_mag, fund1_mag} <= fund_set;
		{harm2_3_mag, harm2_2_mag, harm2_1_mag} <= harm_set;
	end
endmodule // ihd_src

// >>> testbench/ihd_props.sv
// Assertion checker for the inrush detector
module ihd_props (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pslverr,
	input wire logic [11:0] paddr,
	// Inputs
	input wire logic [15:0] fund1_mag,
	input wire logic [15:0] fund2_mag,
	input wire logic [15:0] harm2_3_mag,
	input wire logic block_input,
	// Outputs
	input wire logic inrush_phase1_flag,
	input wire logic inrush_phase2_flag,
	input wire logic inrush_phase3_flag,
	input wire logic inrush_any_flag,
	input wire logic event_on,
	input wire logic event_off
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_rise; !inrush_any_flag ##1 inrush_any_flag; endsequence
	sequence s_fall; inrush_any_flag ##1 !inrush_any_flag; endsequence
	chk_any_or: assert property (inrush_any_flag == (inrush_phase1_flag | inrush_phase2_flag | inrush_phase3_flag))
		else $error("general flag differs from phase OR");
	chk_block_clear: assert property (block_input |=> !inrush_any_flag && !inrush_phase1_flag)
		else $error("flag high while blocked");
	chk_event_on: assert property (s_rise |-> event_on)
		else $error("no on event with rise");
	chk_event_off: assert property (s_fall |-> event_off)
		else $error("no off event with fall");
	chk_on_cause: assert property (event_on |-> inrush_any_flag && !$past(inrush_any_flag) && !event_off)
		else $error("on event without rise");
	chk_ph1_nofund: assert property (fund1_mag == 16'h0000 |=> !inrush_phase1_flag)
		else $error("phase 1 flag with no fundamental");
	chk_ph2_nofund: assert property (fund2_mag == 16'h0000 |=> !inrush_phase2_flag)
		else $error("phase 2 flag with no fundamental");
	chk_ph3_noharm: assert property (harm2_3_mag == 16'h0000 |=> !inrush_phase3_flag)
		else $error("phase 3 flag with no harmonic");
	chk_err_access: assert property (psel && penable |->
		pslverr == ((paddr > ihd_pkg::OFF_RATED) || (paddr[1:0] != 2'b00)))
		else $error("error response does not match address");
endmodule // ihd_props
bind ihd_top ihd_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pslverr(pslverr), .paddr(paddr), .fund1_mag(fund1_mag), .fund2_mag(fund2_mag), .harm2_3_mag(harm2_3_mag),
	.block_input(block_input), .inrush_phase1_flag(inrush_phase1_flag), .inrush_phase2_flag(inrush_phase2_flag),
	.inrush_phase3_flag(inrush_phase3_flag), .inrush_any_flag(inrush_any_flag), .event_on(event_on),
	.event_off(event_off));

// >>> testbench/inrush_harmonic_detector_tb.sv
// Self-checking testbench for the inrush detector
module inrush_harmonic_detector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, block_input, irq, event_on, event_off, err;
	logic p1, p2, p3, pa;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [47:0] fund_set, harm_set, h;
	logic [15:0] f1, f2, f3, h1, h2, h3;
	int failures, comparisons, ons, offs;
	ihd_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fund1_mag(f1), .fund2_mag(f2), .fund3_mag(f3), .harm2_1_mag(h1), .harm2_2_mag(h2), .harm2_3_mag(h3),
		.block_input(block_input), .inrush_phase1_flag(p1), .inrush_phase2_flag(p2), .inrush_phase3_flag(p3),
		.inrush_any_flag(pa), .event_on(event_on), .event_off(event_off), .irq(irq));
	ihd_src src (.pclk(pclk), .fund_set(fund_set), .harm_set(harm_set), .fund1_mag(f1), .fund2_mag(f2),
		.fund3_mag(f3), .harm2_1_mag(h1), .harm2_2_mag(h2), .harm2_3_mag(h3));
	////////////////////////////////////////////////////////////
	initial begin
		pclk = 0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (event_on === 1'b1) ons++;
		if (event_off === 1'b1) offs++;
	end
	task close_out;
		$display("failures %0d comparisons %0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk($sformatf("reg %h", a), e, rdat);
	endtask
	task setm(input logic [47:0] f, input logic [47:0] hm);
		@(posedge pclk);
		fund_set <= f;
		harm_set <= hm;
		repeat (4) @(posedge pclk);
	endtask
	task flg(input logic [3:0] e);
		chk("flags", {28'h0, e}, {28'h0, pa, p3, p2, p1});
	endtask
	////////////////////////////////////////////////////////////
	task t_regs;
		rd(ihd_pkg::OFF_CTRL, 0);
		rd(ihd_pkg::OFF_RATIO, 32'h0000_000f);
		rd(ihd_pkg::OFF_MINF, 32'h0000_001e);
		apb(0, 12'h01c, 0);
		chk("slverr", 1, {31'h0, err});
		apb(1, ihd_pkg::OFF_RATIO, 32'h0000_0033);
		rd(ihd_pkg::OFF_RATIO, 32'h0000_0032);
		apb(1, ihd_pkg::OFF_RATIO, 32'h0000_0004);
		rd(ihd_pkg::OFF_RATIO, 32'h0000_0005);
		apb(1, ihd_pkg::OFF_MINF, 32'h0000_0013);
		rd(ihd_pkg::OFF_MINF, 32'h0000_0014);
		apb(1, ihd_pkg::OFF_MINF, 32'h0000_0065);
		rd(ihd_pkg::OFF_MINF, 32'h0000_0064);
		apb(1, ihd_pkg::OFF_RATIO, 32'h0000_000f);
		apb(1, ihd_pkg::OFF_MINF, 32'h0000_001e);
	endtask
	task t_detect;
		setm({3{16'h07d0}}, {3{16'h03e8}});
		flg(4'h0);
		apb(1, ihd_pkg::OFF_CTRL, 1);
		apb(1, ihd_pkg::OFF_IRQ_MASK, 3);
		for (int p = 0; p < 3; p++) begin
			h = {3{16'h012c}};
			h[p*16 +: 16] = 16'h012d;
			setm({3{16'h07d0}}, h);
			flg(4'h8 | (4'h1 << p));
		end
		setm({3{16'h07d0}}, {3{16'h012c}});
		flg(4'h0);
		chk("events", 32'h0001_0001, {ons[15:0], offs[15:0]});
		setm({3{16'h04cc}}, {3{16'h03e8}});
		flg(4'h0);
		setm({3{16'h04cd}}, {3{16'h03e8}});
		flg(4'hf);
	endtask
	task t_block;
		@(posedge pclk);
		block_input <= 1;
		repeat (3) @(posedge pclk);
		flg(4'h0);
		block_input <= 0;
		repeat (3) @(posedge pclk);
		flg(4'hf);
		chk("events", 32'h0003_0002, {ons[15:0], offs[15:0]});
		chk("irq", 1, {31'h0, irq});
		rd(ihd_pkg::OFF_IRQ_STAT, 3);
		@(posedge pclk);
		chk("irq", 0, {31'h0, irq});
		apb(1, ihd_pkg::OFF_CTRL, 0);
		repeat (3) @(posedge pclk);
		flg(4'h0);
	endtask
	task t_rated;
		apb(1, ihd_pkg::OFF_CTRL, 1);
		apb(1, ihd_pkg::OFF_RATED, 32'h0000_0800);
		rd(ihd_pkg::OFF_RATED, 32'h0000_0800);
		rd(ihd_pkg::OFF_IRQ_MASK, 32'h0000_0003);
		setm({3{16'h0266}}, {3{16'h00c8}});
		flg(4'h0);
		setm({3{16'h0267}}, {3{16'h00c8}});
		flg(4'hf);
		rd(ihd_pkg::OFF_FLAGS, 32'h0000_000f);
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{presetn, psel, penable, pwrite, block_input, paddr, pwdata, fund_set, harm_set} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_regs;
		t_detect;
		t_block;
		t_rated;
		close_out;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		close_out;
	end
endmodule // inrush_harmonic_detector_tb
